// ---- design/tgp_pkg.sv ----
/*
 Shared constants, register map and carrier types of the ten-gigabit port
 control block. Assumes a single 10 MHz clock domain for all users.
*/
package tgp_pkg;
	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int AW  = 8;
	localparam int DW  = 32;
	localparam int CW  = 16;
	localparam int FD  = 8;
	localparam int FCW = 4;
	localparam int NCNT = 5;
	localparam int NTAG = 3;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [AW-1:0] A_RST    = 8'h00;
	localparam logic [AW-1:0] A_ENA    = 8'h04;
	localparam logic [AW-1:0] A_MODE   = 8'h08;
	localparam logic [AW-1:0] A_MAXLEN = 8'h0C;
	localparam logic [AW-1:0] A_NTAGS  = 8'h10;
	localparam logic [AW-1:0] A_TAG0   = 8'h14;
	localparam logic [AW-1:0] A_ADV    = 8'h20;
	localparam logic [AW-1:0] A_LFS    = 8'h24;
	localparam logic [AW-1:0] A_STAT   = 8'h28;
	localparam logic [AW-1:0] A_PSTK   = 8'h2C;
	localparam logic [AW-1:0] A_PMSK   = 8'h30;
	localparam logic [AW-1:0] A_FSTK   = 8'h34;
	localparam logic [AW-1:0] A_FMSK   = 8'h38;
	localparam logic [AW-1:0] A_ESTK   = 8'h3C;
	localparam logic [AW-1:0] A_EMSK   = 8'h40;
	localparam logic [AW-1:0] A_FIFO   = 8'h44;
	localparam logic [AW-1:0] A_FSTAT  = 8'h48;
	localparam logic [AW-1:0] A_CNT0   = 8'h4C;
	localparam logic [AW-1:0] A_STEP   = 8'h04;

	// ****************************************
	// Reset values and field constants
	// ****************************************
	localparam logic [3:0]  RST_ALL    = 4'hF;
	localparam logic [2:0]  SPD_OFF    = 3'h6;
	localparam logic [2:0]  SPD_10G    = 3'h7;
	localparam logic [13:0] MAXLEN_RST = 14'h05EE;
	localparam logic [13:0] MAXLEN_TOP = 14'h36B0;
	localparam logic [1:0]  NTAGS_RST  = 2'h3;
	localparam logic [15:0] TAG_CTAG   = 16'h8100;
	localparam logic [15:0] TAG_STAG   = 16'h88A8;
	localparam logic [15:0] TAG_RST    = 16'h8100;
	localparam logic [15:0] TAG_BYTES  = 16'h0004;
	localparam logic [1:0]  OS_IDLE    = 2'h0;
	localparam logic [1:0]  OS_RFAULT  = 2'h2;

	// ****************************************
	// Link surveillance timing, in blocks
	// ****************************************
	localparam logic [7:0] LOCK_GOOD = 8'h40;
	localparam logic [7:0] LOSE_WIN  = 8'h40;
	localparam logic [7:0] LOSE_BAD  = 8'h10;
	localparam logic [7:0] BER_WIN   = 8'h7D;
	localparam logic [7:0] BER_BAD   = 8'h10;

	// Sticky bit positions in the coding-layer group
	localparam int PS_LOCK = 0;
	localparam int PS_BER  = 1;
	localparam int PS_OSET = 2;
	localparam int PS_UP   = 3;
	localparam int PS_DOWN = 4;

	typedef enum logic {TGP_HUNT, TGP_LOCKED} tgp_lock_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} tgp_bus_t;

	typedef struct packed {
		logic [3:0]           rst;
		logic [2:0]           speed;
		logic                 rx_en;
		logic                 tx_en;
		logic                 pause_pass;
		logic [1:0]           pre_fmt;
		logic [1:0]           gap_fmt;
		logic                 hdr_crc;
		logic [13:0]          maxlen;
		logic                 tag_chk;
		logic [1:0]           ntags;
		logic [NTAG-1:0][15:0] tag;
		logic [6:0]           adv;
		logic                 lfs_en;
		logic                 unidir;
	} tgp_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        sof;
		logic        eof;
		logic [3:0]  bytes;
		logic        type_valid;
		logic [15:0] etype;
		logic [6:0]  err;
	} tgp_rxf_t;

	typedef struct packed {
		logic          hdr_valid;
		logic          hdr_ok;
		logic          oset_valid;
		logic          oset_fault;
		logic [DW-1:0] oset_data;
		logic          tx_e;
		logic          tx_char;
		logic          rx_e;
		logic          rx_char;
		logic          tx_lpi;
		logic          rx_lpi;
		logic [1:0]    fec_ev;
		logic [1:0]    rx_fault;
		logic          tx_gap;
	} tgp_pcs_t;
endpackage

// ---- design/tgp_port_ctrl.sv ----
/*
 Control and status logic of the ten-gigabit port: configuration registers,
 length checks, fault signalling, link surveillance, ordered-set capture,
 error counters and the five interrupt sources.
 Assumes all inputs are synchronous to clock_i, driven by datapath logic.
*/
// Local design decisions: the strobed register port and the address map.
// Behaviour
// - Five interrupt sources leave the port.
// - Sticky events interrupt only when mask is 1.
// - Three mask groups: coding, fec, low power.
// - Speed 6 stops clocks, 7 runs 10G.
// - Receiver and transmitter have own enables.
// - Pause passthrough bit forwards pause frames.
// - Preamble, gap formats, inner checksum enable.
// - Programmable maximum length up to 14000.
// - Tag-aware check adds 4/8/12 bytes.
// - Tag count programmable, two default types, three custom.
// - Overlong received frame truncated and aborted.
// - Length field errors drop when enabled.
// - Separate advanced checks, shrink check disable.
// - Fault detect answers with ordered set.
// - Unidirectional mode keeps frames, interleaves sets.
// - Block lock after finding 66-bit boundary.
// - Sticky flag on lock gain or loss.
// - High error rate status plus sticky flag.
// - Fault ordered set flagged and stored in FIFO.
// - FIFO fill level and full readable.
// - Five coding-layer error event counters.
`timescale 1ns/1ps
module tgp_port_ctrl
(
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire tgp_pkg::tgp_bus_t bus_i,
	output logic [tgp_pkg::DW-1:0] rdata_o,
	input  wire tgp_pkg::tgp_pcs_t pcs_i,
	input  wire tgp_pkg::tgp_rxf_t rxf_i,
	output tgp_pkg::tgp_cfg_t      cfg_o,
	output logic                   mac_clk_en_o,
	output logic                   mac_rx_run_o,
	output logic                   mac_tx_run_o,
	output logic                   rx_abort_o,
	output logic                   rx_drop_o,
	output logic                   tx_oset_req_o,
	output logic [1:0]             tx_oset_code_o,
	output logic                   tx_hold_o,
	output logic                   block_lock_o,
	output logic                   hi_ber_o,
	output logic                   coding_layer_irq_o,
	output logic                   tx_low_power_change_irq_o,
	output logic                   rx_low_power_change_irq_o,
	output logic                   link_rise_irq_o,
	output logic                   link_fall_irq_o
);
	import tgp_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		tgp_cfg_t              cfg;
		logic [DW-1:0]         rdata;
		logic [4:0]            pstk;
		logic [4:0]            pmsk;
		logic [1:0]            fstk;
		logic [1:0]            fmsk;
		logic [1:0]            estk;
		logic [1:0]            emsk;
		tgp_lock_t             lock;
		logic [7:0]            good;
		logic [7:0]            lwin;
		logic [7:0]            lbad;
		logic [7:0]            bwin;
		logic [7:0]            bbad;
		logic                  hi_ber;
		logic                  link;
		logic                  tx_lpi;
		logic                  rx_lpi;
		logic [FD-1:0][DW-1:0] fifo;
		logic [FCW-2:0]        wp;
		logic [FCW-2:0]        rp;
		logic [FCW-1:0]        fcnt;
		logic [NCNT-1:0][CW-1:0] cnt;
		logic                  in_frame;
		logic                  trunc;
		logic [15:0]           blen;
		logic [1:0]            tags;
		logic                  abort;
		logic                  drop;
		logic                  clk_en;
		logic                  rx_run;
		logic                  tx_run;
		logic                  os_req;
		logic [1:0]            os_code;
		logic                  hold;
		logic [4:0]            irq;
	} tgp_st_t;

	tgp_st_t q;
	tgp_st_t d;

	logic [15:0]     limit;
	logic [15:0]     nlen;
	logic [NCNT-1:0] ev;
	logic            tag_hit;
	logic            bad_hdr;
	logic            lock_up;
	logic            lock_dn;
	logic            link_n;
	logic            push;
	logic            pop;

	always_comb
	begin
		d = q;
		limit = '0;
		nlen = '0;
		ev = '0;
		tag_hit = 1'b0;
		bad_hdr = pcs_i.hdr_valid && !pcs_i.hdr_ok;
		lock_up = 1'b0;
		lock_dn = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		d.abort = 1'b0;
		d.drop = 1'b0;

		// ****************************************
		// Block lock and error rate
		// ****************************************
		case (q.lock)
			TGP_HUNT:
			begin
				if (pcs_i.hdr_valid)
				begin
					d.good = pcs_i.hdr_ok ? q.good + 8'h01 : '0;
					if (pcs_i.hdr_ok && q.good == LOCK_GOOD - 8'h01)
					begin
						d.lock = TGP_LOCKED;
						d.lwin = '0;
						d.lbad = '0;
						lock_up = 1'b1;
					end
				end
			end
			TGP_LOCKED:
			begin
				if (pcs_i.hdr_valid)
				begin
					d.lwin = q.lwin + 8'h01;
					d.lbad = q.lbad + {7'h00, bad_hdr};
					if (bad_hdr && q.lbad == LOSE_BAD - 8'h01)
					begin
						d.lock = TGP_HUNT;
						d.good = '0;
						lock_dn = 1'b1;
					end
					else if (q.lwin == LOSE_WIN - 8'h01)
					begin
						d.lwin = '0;
						d.lbad = '0;
					end
				end
			end
			default:
			begin
				d.lock = TGP_HUNT;
				d.good = '0;
			end
		endcase

		// Error rate window runs only while locked
		if (pcs_i.hdr_valid && q.lock == TGP_LOCKED)
		begin
			d.bwin = q.bwin + 8'h01;
			if (bad_hdr && q.bbad != BER_BAD)
				d.bbad = q.bbad + 8'h01;
			if (bad_hdr && q.bbad == BER_BAD - 8'h01)
				d.hi_ber = 1'b1;
			if (q.bwin == BER_WIN - 8'h01)
			begin
				d.bwin = '0;
				d.bbad = '0;
				if (!(bad_hdr && q.bbad == BER_BAD - 8'h01) && q.bbad < BER_BAD)
					d.hi_ber = 1'b0;
			end
		end
		if (lock_dn)
		begin
			d.bwin = '0;
			d.bbad = '0;
		end

		link_n = (d.lock == TGP_LOCKED) && !d.hi_ber;
		d.link = link_n;
		d.tx_lpi = pcs_i.tx_lpi;
		d.rx_lpi = pcs_i.rx_lpi;

		// ****************************************
		// Ordered-set capture
		// ****************************************
		pop = bus_i.rd && bus_i.addr == A_FIFO && q.fcnt != '0;
		push = pcs_i.oset_valid && pcs_i.oset_fault && q.fcnt != FCW'(FD);
		if (push)
		begin
			d.fifo[q.wp] = pcs_i.oset_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop)
			d.rp = q.rp + 1'b1;
		d.fcnt = q.fcnt + {{(FCW-1){1'b0}}, push} - {{(FCW-1){1'b0}}, pop};

		// ****************************************
		// Error counters
		// ****************************************
		ev[0] = pcs_i.tx_e;
		ev[1] = pcs_i.tx_char;
		ev[2] = bad_hdr && q.lock == TGP_LOCKED;
		ev[3] = pcs_i.rx_e;
		ev[4] = pcs_i.rx_char;
		for (int i = 0; i < NCNT; i++)
			if (ev[i] && q.cnt[i] != {CW{1'b1}})
				d.cnt[i] = q.cnt[i] + 1'b1;

		// ****************************************
		// Receive length checks
		// ****************************************
		limit = {2'b00, q.cfg.maxlen};
		if (q.cfg.tag_chk)
			limit = limit + TAG_BYTES * {14'h0000, q.tags};
		if (rxf_i.valid && rxf_i.sof)
		begin
			d.in_frame = 1'b1;
			d.trunc = 1'b0;
			d.tags = '0;
			d.blen = '0;
		end
		if (rxf_i.type_valid && (rxf_i.sof ? 2'h0 : q.tags) < q.cfg.ntags)
		begin
			tag_hit = rxf_i.etype == TAG_CTAG || rxf_i.etype == TAG_STAG;
			for (int i = 0; i < NTAG; i++)
				if (rxf_i.etype == q.cfg.tag[i])
					tag_hit = 1'b1;
			if (tag_hit)
				d.tags = (rxf_i.sof ? 2'h0 : q.tags) + 2'h1;
		end
		if (rxf_i.valid && (rxf_i.sof || (q.in_frame && !q.trunc)) && q.cfg.rx_en)
		begin
			nlen = (rxf_i.sof ? 16'h0000 : q.blen) + {12'h000, rxf_i.bytes};
			d.blen = nlen;
			if (nlen > limit)
			begin
				d.trunc = 1'b1;
				d.abort = 1'b1;
				d.in_frame = 1'b0;
			end
			else if (rxf_i.eof)
			begin
				d.in_frame = 1'b0;
				// Bit order: eop, sop, sfd, shrink, preamble, oor, inr
				d.drop = (|(rxf_i.err & q.cfg.adv & 7'h77))
					| (rxf_i.err[3] && !q.cfg.adv[3]);
			end
		end

		// ****************************************
		// Fault signalling and clocks
		// ****************************************
		d.clk_en = q.cfg.speed == SPD_10G;
		d.rx_run = d.clk_en && q.cfg.rx_en && !q.cfg.rst[0];
		d.tx_run = d.clk_en && q.cfg.tx_en && !q.cfg.rst[1];
		d.hold = 1'b0;
		d.os_req = 1'b0;
		d.os_code = OS_IDLE;
		if (q.cfg.lfs_en && pcs_i.rx_fault != 2'b00)
		begin
			d.os_code = pcs_i.rx_fault[0] ? OS_RFAULT : OS_IDLE;
			if (q.cfg.unidir)
				d.os_req = pcs_i.tx_gap;
			else
			begin
				d.hold = 1'b1;
				d.os_req = 1'b1;
			end
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				A_RST:
				begin
					d.cfg.rst = bus_i.wdata[3:0];
					d.cfg.speed = bus_i.wdata[6:4];
				end
				A_ENA: {d.cfg.tx_en, d.cfg.rx_en} = bus_i.wdata[1:0];
				A_MODE:
					{d.cfg.hdr_crc, d.cfg.gap_fmt, d.cfg.pre_fmt, d.cfg.pause_pass}
						= bus_i.wdata[5:0];
				A_MAXLEN:
				begin
					d.cfg.maxlen = bus_i.wdata[13:0] > MAXLEN_TOP ? MAXLEN_TOP
						: bus_i.wdata[13:0];
					d.cfg.tag_chk = bus_i.wdata[16];
				end
				A_NTAGS: d.cfg.ntags = bus_i.wdata[1:0];
				A_ADV: d.cfg.adv = bus_i.wdata[6:0];
				A_LFS: {d.cfg.unidir, d.cfg.lfs_en} = bus_i.wdata[1:0];
				A_PSTK: d.pstk = q.pstk & ~bus_i.wdata[4:0];
				A_PMSK: d.pmsk = bus_i.wdata[4:0];
				A_FSTK: d.fstk = q.fstk & ~bus_i.wdata[1:0];
				A_FMSK: d.fmsk = bus_i.wdata[1:0];
				A_ESTK: d.estk = q.estk & ~bus_i.wdata[1:0];
				A_EMSK: d.emsk = bus_i.wdata[1:0];
				default:
				begin
					for (int i = 0; i < NTAG; i++)
						if (bus_i.addr == A_TAG0 + AW'(i) * A_STEP)
							d.cfg.tag[i] = bus_i.wdata[15:0];
					for (int i = 0; i < NCNT; i++)
						if (bus_i.addr == A_CNT0 + AW'(i) * A_STEP)
							d.cnt[i] = '0;
				end
			endcase
		end

		// Sticky sets after the clear, so a same-cycle event survives
		d.pstk[PS_LOCK] = d.pstk[PS_LOCK] | lock_up | lock_dn;
		d.pstk[PS_BER] = d.pstk[PS_BER] | (d.hi_ber && !q.hi_ber);
		d.pstk[PS_OSET] = d.pstk[PS_OSET] | (pcs_i.oset_valid && pcs_i.oset_fault);
		d.pstk[PS_UP] = d.pstk[PS_UP] | (link_n && !q.link);
		d.pstk[PS_DOWN] = d.pstk[PS_DOWN] | (!link_n && q.link);
		d.fstk = d.fstk | pcs_i.fec_ev;
		d.estk[0] = d.estk[0] | (pcs_i.tx_lpi != q.tx_lpi);
		d.estk[1] = d.estk[1] | (pcs_i.rx_lpi != q.rx_lpi);

		// ****************************************
		// Interrupt sources
		// ****************************************
		d.irq[0] = |(d.pstk & d.pmsk) | |(d.fstk & d.fmsk) | |(d.estk & d.emsk);
		d.irq[1] = d.estk[0] && d.emsk[0];
		d.irq[2] = d.estk[1] && d.emsk[1];
		d.irq[3] = d.pstk[PS_UP] && d.pmsk[PS_UP];
		d.irq[4] = d.pstk[PS_DOWN] && d.pmsk[PS_DOWN];

		// ****************************************
		// Register reads
		// ****************************************
		d.rdata = '0;
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				A_RST: d.rdata[6:0] = {q.cfg.speed, q.cfg.rst};
				A_ENA: d.rdata[1:0] = {q.cfg.tx_en, q.cfg.rx_en};
				A_MODE: d.rdata[5:0] = {q.cfg.hdr_crc, q.cfg.gap_fmt, q.cfg.pre_fmt,
					q.cfg.pause_pass};
				A_MAXLEN: d.rdata[16:0] = {q.cfg.tag_chk, 2'b00, q.cfg.maxlen};
				A_NTAGS: d.rdata[1:0] = q.cfg.ntags;
				A_ADV: d.rdata[6:0] = q.cfg.adv;
				A_LFS: d.rdata[1:0] = {q.cfg.unidir, q.cfg.lfs_en};
				A_STAT: d.rdata[2:0] = {q.link, q.hi_ber, q.lock == TGP_LOCKED};
				A_PSTK: d.rdata[4:0] = q.pstk;
				A_PMSK: d.rdata[4:0] = q.pmsk;
				A_FSTK: d.rdata[1:0] = q.fstk;
				A_FMSK: d.rdata[1:0] = q.fmsk;
				A_ESTK: d.rdata[1:0] = q.estk;
				A_EMSK: d.rdata[1:0] = q.emsk;
				A_FIFO: d.rdata = q.fcnt != '0 ? q.fifo[q.rp] : '0;
				A_FSTAT: d.rdata[FCW:0] = {q.fcnt == FCW'(FD), q.fcnt};
				default:
				begin
					for (int i = 0; i < NTAG; i++)
						if (bus_i.addr == A_TAG0 + AW'(i) * A_STEP)
							d.rdata[15:0] = q.cfg.tag[i];
					for (int i = 0; i < NCNT; i++)
						if (bus_i.addr == A_CNT0 + AW'(i) * A_STEP)
							d.rdata[CW-1:0] = q.cnt[i];
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q <= '0;
			q.cfg.rst <= RST_ALL;
			q.cfg.speed <= SPD_10G;
			q.cfg.maxlen <= MAXLEN_RST;
			q.cfg.ntags <= NTAGS_RST;
			q.cfg.tag <= {NTAG{TAG_RST}};
			q.cfg.lfs_en <= 1'b1;
			q.lock <= TGP_HUNT;
		end
		else
			q <= d;
	end

	assign rdata_o = q.rdata;
	assign cfg_o = q.cfg;
	assign mac_clk_en_o = q.clk_en;
	assign mac_rx_run_o = q.rx_run;
	assign mac_tx_run_o = q.tx_run;
	assign rx_abort_o = q.abort;
	assign rx_drop_o = q.drop;
	assign tx_oset_req_o = q.os_req;
	assign tx_oset_code_o = q.os_code;
	assign tx_hold_o = q.hold;
	assign block_lock_o = q.lock == TGP_LOCKED;
	assign hi_ber_o = q.hi_ber;
	assign coding_layer_irq_o = q.irq[0];
	assign tx_low_power_change_irq_o = q.irq[1];
	assign rx_low_power_change_irq_o = q.irq[2];
	assign link_rise_irq_o = q.irq[3];
	assign link_fall_irq_o = q.irq[4];
endmodule

// ---- dv/test_tgp_port_ctrl.sv ----
/*
 Self-checking bench of the port control block.
 Assumes the link partner model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end
module test_tgp_port_ctrl;
	import tgp_pkg::*;
	logic          clk = 0, rstn = 0, slow = 0, bad = 0, hen = 0, oset = 0, ab = 0, dr = 0;
	logic [1:0]    flt = 0;
	int            miscompares = 0, comparisons = 0;
	tgp_bus_t      bus = '0;
	tgp_rxf_t      rxf = '0;
	tgp_pcs_t      ev = '0, lp, pcs;
	tgp_cfg_t      cfg;
	logic [DW-1:0] rdata, q[$];
	logic          clk_en, rx_run, tx_run, abort, drop, lock, ci, ti, ri, lu, lf, hb;
	always #50 clk = ~clk;
	tgp_link_partner lp_model (.clock_i(clk), .slow_i(slow), .run_i(hen), .bad_i(bad),
		.oset_i(oset), .fault_i(flt), .pcs_o(lp));
	always_comb
	begin
		pcs = ev;
		pcs.hdr_valid = lp.hdr_valid;
		pcs.hdr_ok = lp.hdr_ok;
		pcs.oset_valid = lp.oset_valid;
		pcs.oset_fault = lp.oset_fault;
		pcs.oset_data = lp.oset_data;
		pcs.rx_fault = lp.rx_fault;
	end
	tgp_port_ctrl dut (.clock_i(clk), .rstn_i(rstn), .bus_i(bus), .rdata_o(rdata), .pcs_i(pcs),
		.rxf_i(rxf), .cfg_o(cfg), .mac_clk_en_o(clk_en), .mac_rx_run_o(rx_run),
		.mac_tx_run_o(tx_run), .rx_abort_o(abort), .rx_drop_o(drop), .tx_oset_req_o(),
		.tx_oset_code_o(), .tx_hold_o(), .block_lock_o(lock), .hi_ber_o(hb),
		.coding_layer_irq_o(ci), .tx_low_power_change_irq_o(ti),
		.rx_low_power_change_irq_o(ri), .link_rise_irq_o(lu), .link_fall_irq_o(lf));
	// Pulses are caught here so a frame task cannot miss them
	always @(posedge clk)
	begin
		if (abort)
			ab <= 1'b1;
		if (drop)
			dr <= 1'b1;
		if (pcs.oset_valid && pcs.oset_fault && q.size() < FD)
			q.push_back(pcs.oset_data);
	end
	// ****************************************
	// Tasks and expectations
	// ****************************************
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
		logic [DW-1:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask
	task frame(input int nt, input int nb, input logic [6:0] e);
		ab <= 1'b0;
		dr <= 1'b0;
		for (int b = 0; b < nb; b++)
		begin
			rxf.valid <= 1'b1;
			rxf.sof <= (b == 0);
			rxf.eof <= (b == nb - 1);
			rxf.bytes <= 4'h8;
			rxf.type_valid <= (b <= nt);
			rxf.etype <= (b < nt) ? (b[0] ? TAG_STAG : TAG_CTAG) : 16'h0800;
			rxf.err <= (b == nb - 1) ? e : 7'h00;
			@(posedge clk);
		end
		rxf <= '0;
		cyc(3);
	endtask
	function automatic logic exp_abort(int ml, logic tc, int nt, int nb);
		return 8 * nb > ml + (tc ? 4 * nt : 0);
	endfunction
	// Shrink check is the one bit that disables rather than enables
	function automatic logic exp_drop(logic [6:0] adv, logic [6:0] e);
		return (|(adv & e & 7'h77)) | (e[3] & ~adv[3]);
	endfunction
	task conclude;
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#(100 * 90000);
		miscompares++;
		conclude();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic          tc;
		int            nt, nb;
		logic [6:0]    adv, e;
		logic [DW-1:0] d;
		void'($urandom(43062));
		cyc(16);
		rstn <= 1'b1;
		@(posedge clk);
		rc(A_RST, 32'h0000007F);
		rc(A_MAXLEN, 32'h000005EE);
		rc(A_NTAGS, 32'h00000003);
		for (int i = 0; i < NTAG; i++)
			rc(A_TAG0 + AW'(i) * A_STEP, 32'h00008100);
		rc(A_LFS, 32'h00000001);
		rc(8'hFC, 32'h00000000);
		d = $urandom;
		wr(A_TAG0 + A_STEP, d);
		rc(A_TAG0 + A_STEP, {16'h0000, d[15:0]});
		wr(A_MODE, d);
		`CHK({cfg.hdr_crc, cfg.gap_fmt, cfg.pre_fmt, cfg.pause_pass}, d[5:0])
		wr(A_MAXLEN, 32'h00003FFF);
		rc(A_MAXLEN, {18'h0, MAXLEN_TOP});
		wr(A_ENA, 32'h00000003);
		`CHK(rx_run, 1'b0)
		wr(A_RST, 32'h0000007F);
		wr(A_RST, 32'h00000070);
		cyc(1);
		`CHK({rx_run, tx_run}, 2'b11)
		wr(A_ENA, 32'h00000001);
		cyc(1);
		`CHK({rx_run, tx_run}, 2'b10)
		wr(A_RST, 32'h00000060);
		cyc(1);
		`CHK({clk_en, rx_run}, 2'b00)
		wr(A_RST, 32'h00000070);
		cyc(1);
		`CHK(clk_en, 1'b1)
		wr(A_ENA, 32'h00000003);
		for (int i = 0; i < 30; i++)
		begin
			tc = (i < 2) ? 1'b1 : 1'($urandom);
			nt = (i < 2) ? 3 : $urandom % 4;
			nb = (i < 2) ? 9 + i : 7 + $urandom % 5;
			adv = 7'($urandom);
			e = 7'($urandom);
			wr(A_MAXLEN, {15'h0, tc, 16'h0040});
			wr(A_ADV, {25'h0, adv});
			frame(nt, nb, e);
			`CHK(ab, exp_abort(64, tc, nt, nb))
			`CHK(dr, exp_drop(adv, e) & ~exp_abort(64, tc, nt, nb))
		end
		wr(A_PMSK, 32'h0000001F);
		slow <= 1'b1;
		hen <= 1'b1;
		for (int i = 0; i < 300 && !lock; i++)
			@(posedge clk);
		hen <= 1'b0;
		`CHK(lock, 1'b1)
		cyc(2);
		rd(A_PSTK, d);
		`CHK(d[0], 1'b1)
		`CHK(ci, 1'b1)
		`CHK(lu, 1'b1)
		wr(A_PMSK, 32'h00000000);
		`CHK({ci, lu}, 2'b00)
		wr(A_PSTK, 32'h0000001F);
		rc(A_PSTK, 32'h00000000);
		slow <= 1'b0;
		bad <= 1'b1;
		hen <= 1'b1;
		cyc(16);
		hen <= 1'b0;
		bad <= 1'b0;
		cyc(3);
		`CHK(lock, 1'b0)
		rd(A_PSTK, d);
		`CHK(d[1:0], 2'b11)
		`CHK(hb, 1'b1)
		wr(A_PMSK, 32'h00000010);
		`CHK(lf, 1'b1)
		rc(A_CNT0 + 2 * A_STEP, 32'h00000010);
		for (int i = 0; i < FD + 1; i++)
		begin
			oset <= 1'b1;
			@(posedge clk);
			oset <= 1'b0;
			@(posedge clk);
		end
		cyc(2);
		rd(A_PSTK, d);
		`CHK(d[2], 1'b1)
		rc(A_FSTAT, 32'h00000018);
		foreach (q[i])
			rc(A_FIFO, q[i]);
		rc(A_FSTAT, 32'h00000000);
		rc(A_FIFO, 32'h00000000);
		wr(A_EMSK, 32'h00000003);
		ev.tx_lpi <= 1'b1;
		cyc(3);
		`CHK(ti, 1'b1)
		ev.rx_lpi <= 1'b1;
		cyc(3);
		`CHK(ri, 1'b1)
		wr(A_EMSK, 32'h00000000);
		`CHK({ti, ri}, 2'b00)
		ev.fec_ev <= 2'b11;
		@(posedge clk);
		ev.fec_ev <= 2'b00;
		cyc(2);
		rc(A_FSTK, 32'h00000003);
		ev.tx_char <= 1'b1;
		ev.rx_e <= 1'b1;
		ev.rx_char <= 1'b1;
		cyc(3);
		ev.tx_char <= 1'b0;
		cyc(2);
		ev.rx_e <= 1'b0;
		cyc(2);
		ev.rx_char <= 1'b0;
		ev.tx_e <= 1'b1;
		cyc(65540);
		ev.tx_e <= 1'b0;
		cyc(2);
		rc(A_CNT0, 32'h0000FFFF);
		rc(A_CNT0 + A_STEP, 32'h00000003);
		rc(A_CNT0 + 3 * A_STEP, 32'h00000005);
		rc(A_CNT0 + 4 * A_STEP, 32'h00000007);
		wr(A_CNT0, 32'h00000000);
		rc(A_CNT0, 32'h00000000);
		for (int i = 0; i < 40; i++)
		begin
			if (i % 8 == 0)
				wr(A_LFS, $urandom % 4);
			flt <= 2'($urandom);
			ev.tx_gap <= 1'($urandom);
			@(posedge clk);
		end
		conclude();
	end
endmodule

// ---- dv/tgp_link_partner.sv ----
/*
 Behavioural link partner: sync headers, fault ordered sets, fault levels.
 Assumes the bench clock; inputs change right after rising edges.
*/
`timescale 1ns/1ps
module tgp_link_partner
(
	input  wire logic         clock_i,
	input  wire logic         slow_i,
	input  wire logic         run_i,
	input  wire logic         bad_i,
	input  wire logic         oset_i,
	input  wire logic [1:0]   fault_i,
	output tgp_pkg::tgp_pcs_t pcs_o
);
	import tgp_pkg::*;
	logic phase_q = 1'b0;
	initial pcs_o = '0;
	// Slow mode sends a block every other cycle
	always @(posedge clock_i)
	begin
		phase_q <= ~phase_q;
		pcs_o.hdr_valid <= run_i && (!slow_i || phase_q);
		pcs_o.hdr_ok <= !bad_i;
		pcs_o.oset_valid <= oset_i;
		pcs_o.oset_fault <= oset_i;
		// Idle data toggles so a stale set never looks valid
		pcs_o.oset_data <= oset_i ? DW'($urandom) : ~pcs_o.oset_data;
		pcs_o.rx_fault <= fault_i;
	end
endmodule

// ---- dv/tgp_port_ctrl_properties.sv ----
/*
 Concurrent checks on the port control block ports.
 Assumes one clock domain and the async active-low reset of the block.
*/
`timescale 1ns/1ps
module tgp_port_ctrl_chk
(
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire tgp_pkg::tgp_bus_t bus_i,
	input  wire logic [31:0]       rdata_o,
	input  wire tgp_pkg::tgp_pcs_t pcs_i,
	input  wire tgp_pkg::tgp_rxf_t rxf_i,
	input  wire tgp_pkg::tgp_cfg_t cfg_o,
	input  wire logic              mac_clk_en_o,
	input  wire logic              mac_rx_run_o,
	input  wire logic              mac_tx_run_o,
	input  wire logic              rx_abort_o,
	input  wire logic              rx_drop_o,
	input  wire logic              tx_oset_req_o,
	input  wire logic [1:0]        tx_oset_code_o,
	input  wire logic              tx_hold_o,
	input  wire logic              block_lock_o
);
	import tgp_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// ****************************************
	// Assertions
	// ****************************************
	speed_off_a: assert property (cfg_o.speed == SPD_OFF [*2] |-> !mac_clk_en_o && !mac_rx_run_o)
		else $error("clocks run with speed off");
	speed_on_a: assert property (cfg_o.speed == SPD_10G [*3] |-> mac_clk_en_o)
		else $error("clocks stopped at 10G speed");
	rx_gate_a: assert property ((!cfg_o.rx_en || cfg_o.rst[0]) [*2] |-> !mac_rx_run_o)
		else $error("receiver runs while disabled");
	tx_gate_a: assert property ((!cfg_o.tx_en || cfg_o.rst[1]) [*2] |-> !mac_tx_run_o)
		else $error("transmitter runs while disabled");
	abort_pulse_a: assert property (rx_abort_o |=> !rx_abort_o)
		else $error("abort longer than one cycle");
	drop_cause_a: assert property (rx_drop_o |-> $past(rxf_i.valid && rxf_i.eof))
		else $error("drop without end of frame");
	fault_answer_a: assert property (cfg_o.lfs_en && !cfg_o.unidir && pcs_i.rx_fault != 2'h0
		|=> tx_hold_o && tx_oset_req_o
		&& tx_oset_code_o == ($past(pcs_i.rx_fault[0]) ? OS_RFAULT : OS_IDLE))
		else $error("fault answer wrong");
	fault_off_a: assert property (!cfg_o.lfs_en |=> !tx_oset_req_o && !tx_hold_o)
		else $error("fault answer while disabled");
	unidir_frames_a: assert property (cfg_o.lfs_en && cfg_o.unidir && pcs_i.rx_fault != 2'h0
		|=> !tx_hold_o && tx_oset_req_o == $past(pcs_i.tx_gap))
		else $error("unidirectional mode wrong");
	lock_cause_a: assert property ($rose(block_lock_o) |-> $past(pcs_i.hdr_valid && pcs_i.hdr_ok))
		else $error("lock without good header");
	maxlen_top_a: assert property (cfg_o.maxlen <= MAXLEN_TOP)
		else $error("maximum length above limit");
	rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h00000000)
		else $error("read data outside read slot");
	// ****************************************
	// Covers
	// ****************************************
	lock_c: cover property ($rose(block_lock_o));
	abort_c: cover property (rx_abort_o);
	drop_c: cover property (rx_drop_o);
	hold_c: cover property (tx_hold_o);
endmodule

bind tgp_port_ctrl tgp_port_ctrl_chk u_chk (.clock_i, .rstn_i, .bus_i, .rdata_o, .pcs_i,
	.rxf_i, .cfg_o, .mac_clk_en_o, .mac_rx_run_o, .mac_tx_run_o, .rx_abort_o, .rx_drop_o,
	.tx_oset_req_o, .tx_oset_code_o, .tx_hold_o, .block_lock_o);
